// [rtl/fsor_defs.vh]
// Constants for the fixed-purpose outputs and redundancy control block.
// Assumes path clock ticks arrive as one-cycle enables synchronous to mclk.
`ifndef FSOR_DEFS_VH
`define FSOR_DEFS_VH

// Rate of the synthesis-block input clock ticks, in kHz.
`define FSOR_SRC_KHZ 16384
// Output rates in kHz.
`define FSOR_COMPOSITE_KHZ 64
`define FSOR_DS1_KHZ 1544
`define FSOR_E1_KHZ 2048
`define FSOR_SYNC_8K_KHZ 8
`define FSOR_SYNC_2K_KHZ 2
// Frame periods in microseconds.
`define FSOR_SYNC_8K_PERIOD_US 125
`define FSOR_SYNC_2K_PERIOD_US 500
// Accumulator width of the line-rate synthesiser.
`define FSOR_NCO_W 24
// Width of the frame counter, enough for one 2 kHz period of ticks.
`define FSOR_FRAME_W 13
// Width of the composite clock divider.
`define FSOR_DIV_W 12
// Select and strap encodings.
`define FSOR_SEL_SECONDARY 1'b0
`define FSOR_SEL_PRIMARY 1'b1
`define FSOR_ROLE_SLAVE 1'b0
`define FSOR_ROLE_MASTER 1'b1
`define FSOR_RATE_DS1 1'b0
`define FSOR_RATE_E1 1'b1
// Values forced in slave role.
`define FSOR_SLAVE_PRIORITY 4'h1
`define FSOR_SLAVE_BUILDOUT 1'b0
`define FSOR_SLAVE_REVERTIVE_SWITCHING_ENABLE 1'b1
// Reset values.
`define FSOR_RST_PRIORITY 4'h0
`define FSOR_RST_BW 8'h00

`endif

// [rtl/fsor_divider.v]
// Divide-by-2N square clock generator driven by a tick enable.
// Assumes tick is a one-cycle enable synchronous to mclk.
module fsor_divider #(
   parameter W = 12
) (
   input wire mclk,
   input wire resetn,
   input wire tick,
   input wire [W-1:0] half_count,
   output reg clk_out
);

   reg [W-1:0] count;

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         count <= {W{1'b0}};
         clk_out <= 1'b0;
      end else if (tick) begin
         // Integer division only, so edges land exactly on source ticks.
         if (count >= half_count - {{(W-1){1'b0}}, 1'b1}) begin
            count <= {W{1'b0}};
            clk_out <= ~clk_out;
         end else begin
            count <= count + {{(W-1){1'b0}}, 1'b1};
         end
      end
   end

endmodule

// [rtl/fsor_top.v]
// Fixed-purpose output clocks, frame syncs and redundancy role forcing.
// Assumes all inputs are synchronous to mclk; path clocks arrive as
// one-cycle tick enables from the two DPLL synthesis blocks.
`include "fsor_defs.vh"

module fsor_top #(
   parameter SRC_KHZ = `FSOR_SRC_KHZ,
   parameter BW_W = 8
) (
   input wire mclk,
   input wire resetn,
   input wire primary_path_tick,
   input wire secondary_path_tick,
   input wire primary_ref_frame,
   input wire secondary_ref_valid,
   input wire third_general_output_clock,
   input wire fixed_outputs_path_select,
   input wire auto_squelch_enable,
   input wire line_rate_output_enable,
   input wire secondary_path_rate_select,
   input wire primary_path_rate_select,
   input wire sync_8k_output_enable,
   input wire sync_2k_output_enable,
   input wire sync_8k_pulse_mode,
   input wire sync_8k_invert,
   input wire sync_2k_pulse_mode,
   input wire sync_2k_invert,
   input wire role_strap,
   input wire [3:0] cross_input_priority,
   input wire phase_buildout_enable,
   input wire revertive_switching_enable,
   input wire [BW_W-1:0] locked_bandwidth_setting,
   input wire [BW_W-1:0] acquisition_bandwidth_setting,
   output reg composite_clock_output,
   output reg line_rate_clock_output,
   output reg frame_sync_8k_output,
   output reg frame_sync_2k_output,
   output reg role_strap_status,
   output reg [3:0] cross_input_priority_eff,
   output reg phase_buildout_enable_eff,
   output reg revertive_switching_enable_eff,
   output reg [BW_W-1:0] primary_bandwidth_eff
);

   localparam NW = `FSOR_NCO_W;
   localparam FW = `FSOR_FRAME_W;
   localparam DW = `FSOR_DIV_W;

   // Half period of the composite clock in source ticks.
   localparam [31:0] COMPOSITE_HALF_W =
      SRC_KHZ / (2 * `FSOR_COMPOSITE_KHZ);
   localparam [DW-1:0] COMPOSITE_HALF = COMPOSITE_HALF_W[DW-1:0];
   // Frame periods in source ticks, cut to the counter width on purpose.
   localparam [31:0] PERIOD_8K_W = SRC_KHZ / `FSOR_SYNC_8K_KHZ;
   localparam [31:0] HALF_8K_W = SRC_KHZ / (2 * `FSOR_SYNC_8K_KHZ);
   localparam [31:0] PERIOD_2K_M1_W =
      SRC_KHZ * `FSOR_SYNC_2K_PERIOD_US / 1000 - 1;
   localparam [31:0] HALF_2K_W = SRC_KHZ / (2 * `FSOR_SYNC_2K_KHZ);
   localparam [FW-1:0] PERIOD_8K = PERIOD_8K_W[FW-1:0];
   localparam [FW-1:0] HALF_8K = HALF_8K_W[FW-1:0];
   localparam [FW-1:0] PERIOD_2K_M1 = PERIOD_2K_M1_W[FW-1:0];
   localparam [FW-1:0] HALF_2K = HALF_2K_W[FW-1:0];
   // Phase increments of the line-rate synthesiser.
   localparam [63:0] DS1_INC_W =
      (64'd1544 << NW) / SRC_KHZ;
   localparam [63:0] E1_INC_W =
      (64'd2048 << NW) / SRC_KHZ;
   localparam [NW-1:0] DS1_INC = DS1_INC_W[NW-1:0];
   localparam [NW-1:0] E1_INC = E1_INC_W[NW-1:0];

   // Pulse shaper states.
   localparam [1:0] PS_IDLE = 2'b00;
   localparam [1:0] PS_ARMED = 2'b01;
   localparam [1:0] PS_LOW = 2'b10;

   // Source selection for the composite and line-rate outputs.
   reg src_tick;
   reg rate_e1;
   reg squelch;
   reg [NW-1:0] nco_inc;

   always @* begin
      if (fixed_outputs_path_select == `FSOR_SEL_PRIMARY) begin
         src_tick = primary_path_tick;
         rate_e1 = primary_path_rate_select;
      end else begin
         src_tick = secondary_path_tick;
         rate_e1 = secondary_path_rate_select;
      end
      nco_inc = (rate_e1 == `FSOR_RATE_E1) ? E1_INC : DS1_INC;
   end

   always @* begin
      squelch = (fixed_outputs_path_select == `FSOR_SEL_SECONDARY) &&
         auto_squelch_enable && !secondary_ref_valid;
   end

   wire composite_raw;

   fsor_divider #(
      .W(DW)
   ) u_composite_div (
      .mclk(mclk),
      .resetn(resetn),
      .tick(src_tick),
      .half_count(COMPOSITE_HALF),
      .clk_out(composite_raw)
   );

   // phase accumulator synthesis
   // The DS1 rate is not an integer fraction of the source, so its edges
   // carry up to one source tick of jitter; that is the price of
   // reaching both line rates from one source.
   reg [NW-1:0] nco_acc;

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         nco_acc <= {NW{1'b0}};
      end else if (src_tick) begin
         nco_acc <= nco_acc + nco_inc;
      end
   end

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         composite_clock_output <= 1'b0;
         line_rate_clock_output <= 1'b0;
      end else begin
         composite_clock_output <= squelch ? 1'b0 : composite_raw;
         line_rate_clock_output <= (squelch || !line_rate_output_enable)
            ? 1'b0 : nco_acc[NW-1];
      end
   end

   // Effective role settings.
   wire is_slave = (role_strap == `FSOR_ROLE_SLAVE);

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         role_strap_status <= `FSOR_ROLE_SLAVE;
         cross_input_priority_eff <= `FSOR_RST_PRIORITY;
         phase_buildout_enable_eff <= `FSOR_SLAVE_BUILDOUT;
         revertive_switching_enable_eff <= `FSOR_SLAVE_REVERTIVE_SWITCHING_ENABLE;
         primary_bandwidth_eff <= {BW_W{1'b0}};
      end else begin
         role_strap_status <= role_strap;
         if (is_slave) begin
            cross_input_priority_eff <= `FSOR_SLAVE_PRIORITY;
            phase_buildout_enable_eff <= `FSOR_SLAVE_BUILDOUT;
            revertive_switching_enable_eff <= `FSOR_SLAVE_REVERTIVE_SWITCHING_ENABLE;
            primary_bandwidth_eff <= acquisition_bandwidth_setting;
         end else begin
            cross_input_priority_eff <= cross_input_priority;
            phase_buildout_enable_eff <= phase_buildout_enable;
            revertive_switching_enable_eff <= revertive_switching_enable;
            primary_bandwidth_eff <= locked_bandwidth_setting;
         end
      end
   end

   // Frame counter on the primary path; one counter serves both syncs
   // so the 8 kHz and 2 kHz falling edges coincide.
   reg [FW-1:0] frame_count;
   reg [FW-1:0] next_frame_count;
   wire [FW-1:0] count_8k = frame_count % PERIOD_8K;
   reg realign;

   // reference phase alignment
   // Build-out hides reference phase, so realignment only happens
   // while it is effectively off.
   always @* begin
      realign = primary_ref_frame && !phase_buildout_enable_eff;
      if (realign) begin
         next_frame_count = {FW{1'b0}};
      end else if (!primary_path_tick) begin
         next_frame_count = frame_count;
      end else if (frame_count == PERIOD_2K_M1) begin
         next_frame_count = {FW{1'b0}};
      end else begin
         next_frame_count = frame_count + {{(FW-1){1'b0}}, 1'b1};
      end
   end

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         frame_count <= {FW{1'b0}};
      end else begin
         frame_count <= next_frame_count;
      end
   end

   // shared falling edge
   // Square forms are low in the first half so both fall at count zero.
   wire sq_8k = (count_8k >= HALF_8K);
   wire sq_2k = (frame_count >= HALF_2K);
   wire frame_moves = primary_path_tick || realign;
   wire mark_8k = frame_moves &&
      (next_frame_count % PERIOD_8K == {FW{1'b0}}) &&
      (next_frame_count != frame_count);
   wire mark_2k = frame_moves && (next_frame_count == {FW{1'b0}}) &&
      (next_frame_count != frame_count);

   // Third output clock edge detect; it is a synchronous input.
   reg oc3_prev;
   wire oc3_rise = third_general_output_clock && !oc3_prev;

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         oc3_prev <= 1'b0;
      end else begin
         oc3_prev <= third_general_output_clock;
      end
   end

   // Pulse shapers: a frame mark arms, the next third-clock rising edge
   // starts the low pulse, the one after ends it.
   reg [1:0] ps_8k;
   reg [1:0] ps_2k;
   reg [1:0] next_ps_8k;
   reg [1:0] next_ps_2k;

   always @* begin
      case (ps_8k)
         PS_IDLE: begin
            next_ps_8k = mark_8k ? PS_ARMED : PS_IDLE;
         end
         PS_ARMED: begin
            next_ps_8k = oc3_rise ? PS_LOW : PS_ARMED;
         end
         PS_LOW: begin
            // A new mark is kept only if it comes with the rise that ends the low pulse.
            if (oc3_rise) begin
               next_ps_8k = mark_8k ? PS_ARMED : PS_IDLE;
            end else begin
               next_ps_8k = PS_LOW;
            end
         end
         default: begin
            next_ps_8k = PS_IDLE;
         end
      endcase
   end

   always @* begin
      case (ps_2k)
         PS_IDLE: begin
            next_ps_2k = mark_2k ? PS_ARMED : PS_IDLE;
         end
         PS_ARMED: begin
            next_ps_2k = oc3_rise ? PS_LOW : PS_ARMED;
         end
         PS_LOW: begin
            if (oc3_rise) begin
               next_ps_2k = mark_2k ? PS_ARMED : PS_IDLE;
            end else begin
               next_ps_2k = PS_LOW;
            end
         end
         default: begin
            next_ps_2k = PS_IDLE;
         end
      endcase
   end

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ps_8k <= PS_IDLE;
         ps_2k <= PS_IDLE;
      end else begin
         ps_8k <= next_ps_8k;
         ps_2k <= next_ps_2k;
      end
   end

   reg level_8k;
   reg level_2k;

   always @* begin
      if (sync_8k_pulse_mode) begin
         level_8k = (ps_8k != PS_LOW);
      end else begin
         level_8k = sq_8k;
      end
      if (sync_2k_pulse_mode) begin
         level_2k = (ps_2k != PS_LOW);
      end else begin
         level_2k = sq_2k;
      end
   end

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         frame_sync_8k_output <= 1'b0;
         frame_sync_2k_output <= 1'b0;
      end else begin
         frame_sync_8k_output <= sync_8k_output_enable &
            (level_8k ^ sync_8k_invert);
         frame_sync_2k_output <= sync_2k_output_enable &
            (level_2k ^ sync_2k_invert);
      end
   end

endmodule

// [testbench/fsor_chk.sv]
// Checker of the composite, line-rate and 8 kHz sync outputs and the role forcing of fsor_top.
// Assumes binding into fsor_top; a single clock domain on mclk.
module fsor_chk #(
   parameter BW_W = 8
) (
   input wire mclk,
   input wire resetn,
   input wire role_strap,
   input wire [3:0] cross_input_priority,
   input wire phase_buildout_enable,
   input wire revertive_switching_enable,
   input wire [BW_W-1:0] locked_bandwidth_setting,
   input wire [BW_W-1:0] acquisition_bandwidth_setting,
   input wire role_strap_status,
   input wire [3:0] cross_input_priority_eff,
   input wire phase_buildout_enable_eff,
   input wire revertive_switching_enable_eff,
   input wire [BW_W-1:0] primary_bandwidth_eff,
   input wire fixed_outputs_path_select,
   input wire auto_squelch_enable,
   input wire secondary_ref_valid,
   input wire line_rate_output_enable,
   input wire sync_8k_output_enable,
   input wire sync_8k_pulse_mode,
   input wire sync_8k_invert,
   input wire composite_clock_output,
   input wire line_rate_clock_output,
   input wire frame_sync_8k_output
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   property p_status;
      $past(resetn) |-> role_strap_status == $past(role_strap);
   endproperty
   a_status: assert property (p_status)
      else $error("status bit wrong");
   property p_prio;
      $past(resetn) && !$past(role_strap)
         |-> cross_input_priority_eff == 4'h1;
   endproperty
   a_prio: assert property (p_prio)
      else $error("slave priority wrong");
   property p_pbo;
      $past(resetn) && !$past(role_strap)
         |-> !phase_buildout_enable_eff && revertive_switching_enable_eff;
   endproperty
   a_pbo: assert property (p_pbo)
      else $error("slave buildout or revertive_switching_enable wrong");
   property p_bw;
      $past(resetn) && !$past(role_strap)
         |-> primary_bandwidth_eff == $past(acquisition_bandwidth_setting);
   endproperty
   a_bw: assert property (p_bw)
      else $error("slave bandwidth wrong");
   property p_master;
      $past(resetn) && $past(role_strap)
         |-> cross_input_priority_eff == $past(cross_input_priority)
         && phase_buildout_enable_eff == $past(phase_buildout_enable)
         && revertive_switching_enable_eff == $past(revertive_switching_enable)
         && primary_bandwidth_eff == $past(locked_bandwidth_setting);
   endproperty
   a_master: assert property (p_master)
      else $error("master settings altered");
   property p_lr_off;
      !line_rate_output_enable [*3] |-> !line_rate_clock_output;
   endproperty
   a_lr_off: assert property (p_lr_off)
      else $error("line rate driven while off");
   property p_squelch;
      (!fixed_outputs_path_select && auto_squelch_enable
         && !secondary_ref_valid) [*3]
         |-> !composite_clock_output && !line_rate_clock_output;
   endproperty
   a_squelch: assert property (p_squelch)
      else $error("outputs not squelched");
   property p_8k_off;
      !sync_8k_output_enable [*3] |-> !frame_sync_8k_output;
   endproperty
   a_8k_off: assert property (p_8k_off)
      else $error("8k sync driven while off");
   // The source model gives the third clock a period of eight cycles.
   property p_8k_pulse;
      $fell(frame_sync_8k_output) && sync_8k_pulse_mode
         && sync_8k_output_enable && !sync_8k_invert
         |-> ##1 !frame_sync_8k_output [*3] ##[1:8] frame_sync_8k_output;
   endproperty
   a_8k_pulse: assert property (p_8k_pulse)
      else $error("8k pulse width wrong");
endmodule

bind fsor_top fsor_chk #(.BW_W(BW_W)) u_chk (.*);

// [testbench/fsor_mate.sv]
// Model of the two synthesis sources and the third output clock.
// Assumes the bench owns mclk; ticks are one-cycle enables on mclk.
module fsor_mate (
   input wire mclk,
   input wire resetn,
   input wire pri_run,
   input wire sec_run,
   input wire ref_pulse,
   output reg primary_path_tick,
   output reg secondary_path_tick,
   output reg third_general_output_clock,
   output wire primary_ref_frame
);
   timeunit 1ns;
   timeprecision 1ps;
   reg [1:0] oc3_cnt;
   // The bench decides when a reference frame edge arrives.
   assign primary_ref_frame = ref_pulse;
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         primary_path_tick <= 1'h0;
         secondary_path_tick <= 1'h0;
         third_general_output_clock <= 1'h0;
         oc3_cnt <= 2'h0;
      end else begin
         primary_path_tick <= pri_run;
         secondary_path_tick <= sec_run;
         oc3_cnt <= oc3_cnt + 2'h1;
         if (oc3_cnt == 2'h3) begin
            third_general_output_clock <= ~third_general_output_clock;
         end
      end
   end
endmodule

// [testbench/fsor_top_tb.sv]
// Self-checking bench of fsor_top with its source model.
// Assumes default rates; source ticks come on every cycle except in the fx case that stops the secondary.
module fsor_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'h0, resetn = 1'h0, pri_run = 1'h1, sec_run = 1'h1;
   logic primary_path_tick, secondary_path_tick, primary_ref_frame;
   logic third_general_output_clock, role_strap = 1'h1, ref_pulse = 1'h0;
   logic fixed_outputs_path_select = 1'h1, auto_squelch_enable = 1'h0;
   logic secondary_ref_valid = 1'h0, line_rate_output_enable = 1'h1;
   logic secondary_path_rate_select = 1'h0, primary_path_rate_select = 1'h1;
   logic sync_8k_output_enable = 1'h1, sync_2k_output_enable = 1'h1;
   logic sync_8k_pulse_mode = 1'h0, sync_8k_invert = 1'h0;
   logic sync_2k_pulse_mode = 1'h0, sync_2k_invert = 1'h0;
   logic [3:0] cross_input_priority = 4'h0, cross_input_priority_eff;
   logic phase_buildout_enable = 1'h0, revertive_switching_enable = 1'h0;
   logic [7:0] locked_bandwidth_setting = 8'h0, primary_bandwidth_eff;
   logic [7:0] acquisition_bandwidth_setting = 8'h0;
   logic composite_clock_output, line_rate_clock_output, role_strap_status;
   logic frame_sync_8k_output, frame_sync_2k_output;
   logic phase_buildout_enable_eff, revertive_switching_enable_eff;
   int fails = 0, tests_run = 0, n_comp, n_lr, hi8, f8, hi2, f2;

   fsor_top dut (.*);
   fsor_mate mate (.*);

   always #12.5 mclk = ~mclk;

   task automatic conclude();
      if (fails == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t got %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #2;
   endtask

   // Counts composite edges, line-rate rising edges, and high cycles and falling edges of the two syncs, over n cycles.
   task automatic win(input int n);
      logic pc, pl, p8, p2;
      {n_comp, n_lr, hi8, f8, hi2, f2} = '0;
      repeat (n) begin
         {pc, pl, p8, p2} = {composite_clock_output, line_rate_clock_output,
            frame_sync_8k_output, frame_sync_2k_output};
         cyc(1);
         n_comp += (composite_clock_output !== pc);
         n_lr += (line_rate_clock_output && !pl);
         hi8 += frame_sync_8k_output;
         f8 += (!frame_sync_8k_output && p8);
         hi2 += frame_sync_2k_output;
         f2 += (!frame_sync_2k_output && p2);
      end
   endtask

   task automatic t_role();
      {cross_input_priority, phase_buildout_enable,
         revertive_switching_enable} = 6'h26;
      locked_bandwidth_setting = 8'h3c;
      acquisition_bandwidth_setting = 8'hc3;
      role_strap = 1'h0;
      cyc(2);
      chk(role_strap_status, 0);
      chk(cross_input_priority_eff, 1);
      chk({phase_buildout_enable_eff, revertive_switching_enable_eff}, 1);
      chk(primary_bandwidth_eff, 8'hc3);
      role_strap = 1'h1;
      cyc(2);
      chk(role_strap_status, 1);
      chk({cross_input_priority_eff, phase_buildout_enable_eff,
         revertive_switching_enable_eff, primary_bandwidth_eff}, 'h263c);
   endtask

   // Window of 2048 ticks: 16 composite edges, 256 E1 or 193 DS1 cycles.
   task automatic fx(input logic [4:0] c, input int ec, input int el);
      {fixed_outputs_path_select, auto_squelch_enable, secondary_ref_valid,
         line_rate_output_enable, sec_run} = c;
      cyc(8);
      win(2048);
      chk(n_comp, ec);
      chk(n_lr, el);
   endtask

   task automatic sy(input logic [3:0] m, input int e8, input int ef8,
                     input int e2, input int ef2);
      {sync_8k_pulse_mode, sync_8k_invert, sync_2k_pulse_mode,
         sync_2k_invert} = m;
      cyc(8192);
      win(8192);
      chk(hi8, e8);
      chk(f8, ef8);
      chk(hi2, e2);
      chk(f2, ef2);
   endtask

   task automatic t_sync();
      int i = 0;
      sy(4'h2, 4096, 4, 8184, 1);
      sy(4'hd, 32, 4, 4096, 1);
      sy(4'hb, 8160, 4, 8, 1);
      {sync_8k_pulse_mode, sync_8k_invert, sync_2k_pulse_mode,
         sync_2k_invert} = 4'h4;
      cyc(16);
      while (frame_sync_2k_output !== 1'h1 && i < 9000) begin
         cyc(1);
         i++;
      end
      while (frame_sync_2k_output !== 1'h0 && i < 9000) begin
         cyc(1);
         i++;
      end
      chk(i < 9000, 1);
      chk(frame_sync_8k_output, 1);
      {sync_8k_output_enable, sync_2k_output_enable} = 2'h0;
      cyc(4);
      chk({frame_sync_8k_output, frame_sync_2k_output}, 0);
   endtask

   // A reference frame edge is ignored under build-out, then honoured.
   task automatic t_align();
      int i = 0;
      {sync_8k_output_enable, sync_2k_output_enable} = 2'h3;
      {sync_8k_pulse_mode, sync_8k_invert, sync_2k_pulse_mode,
         sync_2k_invert} = 4'h0;
      cyc(2);
      while (frame_sync_2k_output !== 1'h0 && i < 9000) begin
         cyc(1);
         i++;
      end
      while (frame_sync_2k_output !== 1'h1 && i < 9000) begin
         cyc(1);
         i++;
      end
      chk(i < 9000, 1);
      ref_pulse = 1'h1;
      cyc(1);
      ref_pulse = 1'h0;
      cyc(2);
      chk(frame_sync_2k_output, 1);
      phase_buildout_enable = 1'h0;
      cyc(2);
      ref_pulse = 1'h1;
      cyc(1);
      ref_pulse = 1'h0;
      cyc(2);
      chk({frame_sync_8k_output, frame_sync_2k_output}, 0);
      cyc(1022);
      chk(frame_sync_8k_output, 0);
      cyc(1);
      chk(frame_sync_8k_output, 1);
   endtask

   initial begin
      repeat (10) @(posedge mclk);
      #2;
      resetn = 1'h1;
      t_role();
      fx(5'h13, 16, 256);
      fx(5'h1b, 16, 256);
      fx(5'h03, 16, 193);
      fx(5'h0b, 0, 0);
      fx(5'h0f, 16, 193);
      fx(5'h02, 0, 0);
      fx(5'h05, 16, 0);
      {secondary_path_rate_select, primary_path_rate_select} = 2'h2;
      fx(5'h13, 16, 193);
      fx(5'h03, 16, 256);
      t_sync();
      t_align();
      conclude();
   end

   // The scenarios take about 80000 cycles; this leaves some margin.
   initial begin
      #(100000 * 25);
      fails++;
      conclude();
   end
endmodule
